/* hdl/mtr_pkg.sv */
// constants, field layout and types of the translation register block
//
// Functional notes
// - both resets clear the control register; manual reset leaves staging and fault registers untouched.
// - a taken fault loads the page number field with fault address bits 31..10.
// - the process tag in entry-high bits 7..0 changes only by software.
// - page number sits in bits 31..10; 22/20/16/12 bits count per page size.
// - entry load copies staged high and low contents to the counter-selected entry.
// - entry-low bits 0..3: write-through, shared, written, cacheable.
// - entry-low bits 6..5 give the four access right codes.
// - entry-low bit 8 is valid; cleared by power-on reset only.
// - frame number bits 28..10 are used from bit 10, 12, 16 or 20 upward.
// - table base register is plain software storage with no side effect.
// - a taken fault captures the whole faulting address; software may overwrite it.
// - control bit 0 enables translation; while clear no translation fault is taken.
// - writing 1 to control bit 2 flushes both tables; the bit reads 0.
// - tag compares only for unshared pages, in multiple space or user single space.
// - control bit 9 set makes user store-queue access an address error.
// - replace counter counts unified accesses, not entry loads, wraps at the limit.
// - the replace limit acts only when it is nonzero.
// - age bits 31..26 update on every instruction table entry use without a same-cycle control write.
// - on an instruction table miss the age bits pick the entry to replace.
package mtr_pkg;

    // ------------------------------------------------------------------
    // register addresses (upper three address bits are ignored)
    // ------------------------------------------------------------------
    localparam logic [31:0] MTR_OFS_ENTRY_HIGH = 32'hff00_0000;
    localparam logic [31:0] MTR_OFS_ENTRY_LOW  = 32'hff00_0004;
    localparam logic [31:0] MTR_OFS_TABLE_BASE = 32'hff00_0008;
    localparam logic [31:0] MTR_OFS_FAULT_ADDR = 32'hff00_000c;
    localparam logic [31:0] MTR_OFS_CONTROL    = 32'hff00_0010;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MTR_TAG_MSB    = 7;
    localparam int MTR_VPN_LSB    = 10;
    localparam int MTR_WT_BIT     = 0;
    localparam int MTR_SHARED_BIT = 1;
    localparam int MTR_SZ_LO_BIT  = 4;
    localparam int MTR_PR_LSB     = 5;
    localparam int MTR_SZ_HI_BIT  = 7;
    localparam int MTR_VALID_BIT  = 8;
    localparam int MTR_PPN_LSB    = 10;
    localparam int MTR_PPN_MSB    = 28;
    localparam int MTR_MAP_BIT    = 0;
    localparam int MTR_FLUSH_BIT  = 2;
    localparam int MTR_SINGLE_BIT = 8;
    localparam int MTR_SQ_BIT     = 9;
    localparam int MTR_RC_LSB     = 10;
    localparam int MTR_RL_LSB     = 18;
    localparam int MTR_AGE_LSB    = 26;

    // ------------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------------
    localparam logic [31:0] MTR_CTL_RESET    = 32'h0000_0000;
    localparam logic [31:0] MTR_CTL_WR_MASK  = 32'hfcfc_ff01;
    localparam logic [31:0] MTR_LOW_WR_MASK  = 32'h1fff_fdff;
    localparam logic [31:0] MTR_ONES         = 32'hffff_ffff;
    localparam logic [5:0]  MTR_CNT_TOP      = 6'h3f;

    // age bit set / clear masks per instruction table entry (bit 5 left)
    localparam logic [5:0] MTR_AGE_SET [4] = '{6'h00, 6'h20, 6'h14, 6'h0b};
    localparam logic [5:0] MTR_AGE_CLR [4] = '{6'h38, 6'h06, 6'h01, 6'h00};

    // lowest meaningful address bit per page size
    localparam logic [4:0] MTR_LSB_1K  = 5'h0a;
    localparam logic [4:0] MTR_LSB_4K  = 5'h0c;
    localparam logic [4:0] MTR_LSB_64K = 5'h10;
    localparam logic [4:0] MTR_LSB_1M  = 5'h14;

    // page size, ordered as the {high, low} size bits encode it
    typedef enum logic [1:0] {
        MTR_PG_1K,
        MTR_PG_4K,
        MTR_PG_64K,
        MTR_PG_1M
    } mtr_page_t;

endpackage

/* hdl/mtr_age_logic.sv */
// instruction table age bits and replacement choice
`timescale 1ns/1ps
module mtr_age_logic (
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       manual_reset,
    input  wire logic       use_valid,
    input  wire logic [1:0] use_index,
    input  wire logic       wr_en,
    input  wire logic [5:0] wr_data,
    output logic      [5:0] age_q,
    output logic      [1:0] victim,
    output logic            victim_ok
);

    // ------------------------------------------------------------------
    // age update
    // ------------------------------------------------------------------
    logic [5:0] age_d;
    logic [5:0] used_d;

    // per bit: software write, else set or clear by the entry used, else hold
    genvar i;
    generate
        for (i = 0; i < 6; i++)
        begin : g_age
            assign used_d[i] = mtr_pkg::MTR_AGE_SET[use_index][i] |
                               (age_q[i] & ~mtr_pkg::MTR_AGE_CLR[use_index][i]);
            assign age_d[i]  = wr_en ? wr_data[i] : (use_valid ? used_d[i] : age_q[i]);
        end
    endgenerate

    // age register, zero on both resets
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            age_q <= 6'h00;
        else if (manual_reset)
            age_q <= 6'h00;
        else
            age_q <= age_d;
    end

    // ------------------------------------------------------------------
    // replacement choice
    // ------------------------------------------------------------------
    wire pick0 = (age_q[5:3] == 3'b111);
    wire pick1 = !age_q[5] && (age_q[2:1] == 2'b11);
    wire pick2 = !age_q[4] && !age_q[2] && age_q[0];
    wire pick3 = !age_q[3] && (age_q[1:0] == 2'b00);

    assign victim    = pick0 ? 2'd0 : pick1 ? 2'd1 : pick2 ? 2'd2 : 2'd3;
    assign victim_ok = pick0 | pick1 | pick2 | pick3;

endmodule // mtr_age_logic

/* hdl/mtr_regs.sv */
// translation control and staging registers with fault capture and counters
`timescale 1ns/1ps
module mtr_regs (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        manual_reset,
    input  wire logic        reg_req,
    input  wire logic        reg_write,
    input  wire logic [31:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             reg_ack,
    input  wire logic        fault_valid,
    input  wire logic        fault_is_addr_err,
    input  wire logic [31:0] fault_vaddr,
    input  wire logic        load_entry_instr,
    input  wire logic        ut_access,
    input  wire logic        it_use_valid,
    input  wire logic [1:0]  it_use_index,
    input  wire logic        sq_access,
    input  wire logic        user_mode,
    input  wire logic        entry_shared,
    output logic             ut_wr,
    output logic      [5:0]  ut_index,
    output logic      [31:10] ut_vpn,
    output logic      [7:0]  ut_tag,
    output logic      [28:10] ut_ppn,
    output logic      [8:0]  ut_flags,
    output logic             flush_all_entries,
    output logic             mapping_enable,
    output logic             single_space_select,
    output logic             queue_user_block,
    output logic             sq_addr_error,
    output logic             tag_compare_en,
    output logic             fault_taken,
    output logic      [1:0]  it_victim,
    output logic             it_victim_ok
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [31:0] high_q;
    logic [31:0] low_q;
    logic [31:0] base_q;
    logic [31:0] fault_q;
    logic [31:0] ctl_q;
    logic [5:0]  cnt_q;
    logic [5:0]  cnt_d;
    logic [5:0]  age_q;
    logic [1:0]  victim;
    logic        victim_ok;

    // ------------------------------------------------------------------
    // address decode, both address maps share offset bits 28..0
    // ------------------------------------------------------------------
    wire hit_high = reg_addr[28:0] == mtr_pkg::MTR_OFS_ENTRY_HIGH[28:0];
    wire hit_low  = reg_addr[28:0] == mtr_pkg::MTR_OFS_ENTRY_LOW[28:0];
    wire hit_base = reg_addr[28:0] == mtr_pkg::MTR_OFS_TABLE_BASE[28:0];
    wire hit_flt  = reg_addr[28:0] == mtr_pkg::MTR_OFS_FAULT_ADDR[28:0];
    wire hit_ctl  = reg_addr[28:0] == mtr_pkg::MTR_OFS_CONTROL[28:0];
    wire wr_cyc   = reg_req && reg_write;
    wire wr_high  = wr_cyc && hit_high;
    wire wr_low   = wr_cyc && hit_low;
    wire wr_base  = wr_cyc && hit_base;
    wire wr_flt   = wr_cyc && hit_flt;
    wire wr_ctl   = wr_cyc && hit_ctl;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire       map_en  = ctl_q[mtr_pkg::MTR_MAP_BIT];
    wire       single  = ctl_q[mtr_pkg::MTR_SINGLE_BIT];
    wire       sq_blk  = ctl_q[mtr_pkg::MTR_SQ_BIT];
    wire [5:0] limit   = ctl_q[mtr_pkg::MTR_RL_LSB +: 6];
    wire       flush_w = wr_ctl && reg_wdata[mtr_pkg::MTR_FLUSH_BIT];

    // faults only count while translating, address errors always
    wire fault_acc = fault_valid && (fault_is_addr_err || map_en);

    // ------------------------------------------------------------------
    // read data: control shows counter and age, flush bit reads zero
    // ------------------------------------------------------------------
    wire [31:0] ctl_view = (ctl_q & ~(32'h0000_003f << mtr_pkg::MTR_AGE_LSB))
                         | {age_q, 26'h000_0000};
    wire [31:0] ctl_read = {ctl_view[31:16], cnt_q, ctl_view[9:0]};
    wire [31:0] rd_d     = hit_high ? high_q :
                           hit_low  ? low_q  :
                           hit_base ? base_q :
                           hit_flt  ? fault_q :
                           hit_ctl  ? ctl_read : 32'h0000_0000;

    // ------------------------------------------------------------------
    // replace counter: software write first, then access count
    // ------------------------------------------------------------------
    wire cnt_at_lim = (limit != 6'h00) && (cnt_q == limit);
    wire cnt_step   = ut_access && !load_entry_instr;
    assign cnt_d = wr_ctl     ? reg_wdata[mtr_pkg::MTR_RC_LSB +: 6] :
                   !cnt_step  ? cnt_q :
                   cnt_at_lim ? 6'h00 : 6'(cnt_q + 6'h01);

    // ------------------------------------------------------------------
    // page size decode for the entry copy
    // ------------------------------------------------------------------
    mtr_pkg::mtr_page_t page_size;
    logic [4:0]         keep_lsb;
    assign page_size = mtr_pkg::mtr_page_t'({low_q[mtr_pkg::MTR_SZ_HI_BIT],
                                             low_q[mtr_pkg::MTR_SZ_LO_BIT]});
    assign keep_lsb  = (page_size == mtr_pkg::MTR_PG_1K)  ? mtr_pkg::MTR_LSB_1K  :
                       (page_size == mtr_pkg::MTR_PG_4K)  ? mtr_pkg::MTR_LSB_4K  :
                       (page_size == mtr_pkg::MTR_PG_64K) ? mtr_pkg::MTR_LSB_64K :
                                                            mtr_pkg::MTR_LSB_1M;
    wire [31:0] keep_mask = mtr_pkg::MTR_ONES << keep_lsb;
    wire [31:0] vpn_cut   = high_q & keep_mask;
    wire [31:0] ppn_cut   = low_q & keep_mask;

    // tag takes part unless shared, or privileged in single space
    wire tag_cmp_d = !entry_shared && (!single || user_mode);

    // ------------------------------------------------------------------
    // entry-high: page number from fault wins, tag only from software
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            high_q <= 32'h0000_0000;
        else
        begin
            if (wr_high)
                high_q[mtr_pkg::MTR_TAG_MSB:0] <= reg_wdata[mtr_pkg::MTR_TAG_MSB:0];
            if (fault_acc)
                high_q[31:10] <= fault_vaddr[31:10];
            else if (wr_high)
                high_q[31:10] <= reg_wdata[31:10];
        end
    end

    // entry-low: valid cleared by power-on reset only
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            low_q <= 32'h0000_0000;
        else if (wr_low)
            low_q <= reg_wdata & mtr_pkg::MTR_LOW_WR_MASK;
    end

    // table base: software storage only
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            base_q <= 32'h0000_0000;
        else if (wr_base)
            base_q <= reg_wdata;
    end

    // fault address: capture beats a same-cycle software write
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            fault_q <= 32'h0000_0000;
        else if (fault_acc)
            fault_q <= fault_vaddr;
        else if (wr_flt)
            fault_q <= reg_wdata;
    end

    // control and counter: both resets clear them
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_q <= mtr_pkg::MTR_CTL_RESET;
            cnt_q <= 6'h00;
        end
        else if (manual_reset)
        begin
            ctl_q <= mtr_pkg::MTR_CTL_RESET;
            cnt_q <= 6'h00;
        end
        else
        begin
            if (wr_ctl)
                ctl_q <= reg_wdata & mtr_pkg::MTR_CTL_WR_MASK;
            cnt_q <= cnt_d;
        end
    end

    // bus answer, one cycle after the request
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_ack   <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_ack   <= reg_req;
            reg_rdata <= (reg_req && !reg_write) ? rd_d : 32'h0000_0000;
        end
    end

    // entry copy towards the unified table
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ut_wr    <= 1'b0;
            ut_index <= 6'h00;
            ut_vpn   <= 22'h00_0000;
            ut_tag   <= 8'h00;
            ut_ppn   <= 19'h0_0000;
            ut_flags <= 9'h000;
        end
        else
        begin
            ut_wr <= load_entry_instr;
            if (load_entry_instr)
            begin
                ut_index <= cnt_q;
                ut_vpn   <= vpn_cut[31:10];
                ut_tag   <= high_q[mtr_pkg::MTR_TAG_MSB:0];
                ut_ppn   <= ppn_cut[mtr_pkg::MTR_PPN_MSB:mtr_pkg::MTR_PPN_LSB];
                ut_flags <= low_q[mtr_pkg::MTR_VALID_BIT:0];
            end
        end
    end

    // mode outputs, flush pulse, store-queue check, fault strobe
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            flush_all_entries   <= 1'b0;
            mapping_enable      <= 1'b0;
            single_space_select <= 1'b0;
            queue_user_block    <= 1'b0;
            sq_addr_error       <= 1'b0;
            tag_compare_en      <= 1'b0;
            fault_taken         <= 1'b0;
            it_victim           <= 2'd0;
            it_victim_ok        <= 1'b0;
        end
        else
        begin
            flush_all_entries   <= flush_w;
            mapping_enable      <= map_en;
            single_space_select <= single;
            queue_user_block    <= sq_blk;
            sq_addr_error       <= sq_access && user_mode && sq_blk;
            tag_compare_en      <= tag_cmp_d;
            fault_taken         <= fault_acc;
            it_victim           <= victim;
            it_victim_ok        <= victim_ok;
        end
    end

    // ------------------------------------------------------------------
    // instruction table age bits
    // ------------------------------------------------------------------
    mtr_age_logic u_age (
        .clock        (clock),
        .resetn       (resetn),
        .manual_reset (manual_reset),
        .use_valid    (it_use_valid),
        .use_index    (it_use_index),
        .wr_en        (wr_ctl),
        .wr_data      (reg_wdata[mtr_pkg::MTR_AGE_LSB +: 6]),
        .age_q        (age_q),
        .victim       (victim),
        .victim_ok    (victim_ok)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_ctl_reset_zero:
        assert property (@(posedge clock) disable iff (!resetn)
            manual_reset |=> (ctl_q == 32'h0000_0000) && (cnt_q == 6'h00) && (age_q == 6'h00))
        else $error("control not cleared by manual reset");

    a_fault_vpn_load:
        assert property (@(posedge clock) disable iff (!resetn)
            fault_acc |=> high_q[31:10] == $past(fault_vaddr[31:10]))
        else $error("page number not loaded from fault address");

    a_tag_sw_only:
        assert property (@(posedge clock) disable iff (!resetn || manual_reset)
            !wr_high |=> $stable(high_q[7:0]))
        else $error("process tag changed without software write");

    a_fault_addr_cap:
        assert property (@(posedge clock) disable iff (!resetn)
            fault_acc |=> fault_q == $past(fault_vaddr))
        else $error("fault address not captured");

    a_no_fault_off:
        assert property (@(posedge clock) disable iff (!resetn)
            fault_valid && !fault_is_addr_err && !map_en |=> !fault_taken)
        else $error("translation fault taken while translation disabled");

    a_flush_reads_zero:
        assert property (@(posedge clock) disable iff (!resetn)
            reg_req && !reg_write && hit_ctl |=> reg_ack && !reg_rdata[2])
        else $error("flush bit read back nonzero");

    a_flush_pulse:
        assert property (@(posedge clock) disable iff (!resetn)
            flush_w |=> flush_all_entries ##1 (flush_all_entries == $past(flush_w)))
        else $error("flush pulse wrong");

    a_cnt_wrap_limit:
        assert property (@(posedge clock) disable iff (!resetn || manual_reset)
            cnt_step && !wr_ctl && cnt_at_lim |=> cnt_q == 6'h00)
        else $error("replace counter did not wrap at limit");

    a_cnt_hold_load:
        assert property (@(posedge clock) disable iff (!resetn || manual_reset)
            load_entry_instr && !wr_ctl |=> $stable(cnt_q))
        else $error("replace counter moved on entry load");

    a_sq_user_error:
        assert property (@(posedge clock) disable iff (!resetn)
            sq_access && user_mode |=> sq_addr_error == $past(sq_blk))
        else $error("store queue user check wrong");

    a_age_entry_zero:
        assert property (@(posedge clock) disable iff (!resetn || manual_reset)
            it_use_valid && it_use_index == 2'd0 && !wr_ctl |=> age_q[5:3] == 3'b000)
        else $error("age bits not updated for entry zero");

endmodule // mtr_regs

/* verification/mtr_table_model.sv */
// partner model: valid bits of the unified table written by entry loads
`timescale 1ns/1ps
module mtr_table_model (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ut_wr,
    input  wire logic [5:0]  ut_index,
    input  wire logic [8:0]  ut_flags,
    input  wire logic        flush_all_entries,
    output logic      [63:0] valid_q
);
    // ----------------------------------------
    // table entry valid bits
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            valid_q <= '0;
        else if (flush_all_entries)
            valid_q <= '0;
        else if (ut_wr)
            valid_q[ut_index] <= ut_flags[8];
endmodule // mtr_table_model

/* verification/mmu_translation_registers_tb.sv */
// self-checking bench of the translation register block
`timescale 1ns/1ps
module mmu_translation_registers_tb;
    localparam logic [31:0] HI = mtr_pkg::MTR_OFS_ENTRY_HIGH;
    localparam logic [31:0] LO = mtr_pkg::MTR_OFS_ENTRY_LOW;
    localparam logic [31:0] FA = mtr_pkg::MTR_OFS_FAULT_ADDR;
    localparam logic [31:0] CT = mtr_pkg::MTR_OFS_CONTROL;
    logic clock = 0, resetn = 0, manual_reset = 0, reg_req = 0, reg_write = 0;
    logic fault_valid = 0, fault_is_addr_err = 0, load_entry_instr = 0, ut_access = 0;
    logic it_use_valid = 0, sq_access = 0, user_mode = 0, entry_shared = 0;
    logic [31:0] reg_addr = 0, reg_wdata = 0, fault_vaddr = 0, reg_rdata, d;
    logic [1:0] it_use_index = 0, it_victim, s;
    logic reg_ack, ut_wr, flush_all_entries, mapping_enable, single_space_select;
    logic queue_user_block, sq_addr_error, tag_compare_en, fault_taken, it_victim_ok;
    logic [5:0] ut_index;
    logic [31:10] ut_vpn;
    logic [7:0] ut_tag;
    logic [28:10] ut_ppn;
    logic [8:0] ut_flags;
    logic [63:0] valid_q;
    int error_cnt = 0, compares = 0;
    int sh[4] = '{0, 2, 6, 10};
    int idx[4] = '{3, 2, 1, 0};
    logic [5:0] age[4] = '{6'h0b, 6'h1e, 6'h38, 6'h00};
    logic [1:0] vic[4] = '{2'h2, 2'h1, 2'h0, 2'h3};

    mtr_regs i_dut (
        .clock(clock), .resetn(resetn), .manual_reset(manual_reset),
        .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .fault_valid(fault_valid), .fault_is_addr_err(fault_is_addr_err),
        .fault_vaddr(fault_vaddr), .load_entry_instr(load_entry_instr),
        .ut_access(ut_access), .it_use_valid(it_use_valid), .it_use_index(it_use_index),
        .sq_access(sq_access), .user_mode(user_mode), .entry_shared(entry_shared),
        .ut_wr(ut_wr), .ut_index(ut_index), .ut_vpn(ut_vpn), .ut_tag(ut_tag),
        .ut_ppn(ut_ppn), .ut_flags(ut_flags), .flush_all_entries(flush_all_entries),
        .mapping_enable(mapping_enable), .single_space_select(single_space_select),
        .queue_user_block(queue_user_block), .sq_addr_error(sq_addr_error),
        .tag_compare_en(tag_compare_en), .fault_taken(fault_taken),
        .it_victim(it_victim), .it_victim_ok(it_victim_ok)
    );
    mtr_table_model i_table (
        .clock(clock), .resetn(resetn), .ut_wr(ut_wr), .ut_index(ut_index),
        .ut_flags(ut_flags), .flush_all_entries(flush_all_entries), .valid_q(valid_q)
    );

    always #10 clock = ~clock;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic step;
        @(posedge clock) #1;
    endtask
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] v);
        step; // let an edge pass after the previous request dropped
        reg_req = 1; reg_write = w; reg_addr = a; reg_wdata = v;
        step;
        reg_req = 0;
        chk("reg_ack", 1, reg_ack);
        if (!w) chk("reg_rdata", v, reg_rdata);
    endtask
    task automatic flt(input logic ae, input logic [31:0] a, input logic e);
        step; // let an edge pass after the previous strobe dropped
        fault_is_addr_err = ae; fault_vaddr = a; fault_valid = 1;
        step;
        fault_valid = 0;
        chk("fault_taken", e, fault_taken);
    endtask
    task automatic uta(input int n);
        ut_access = 1;
        repeat (n) step;
        ut_access = 0;
    endtask
    task automatic test_done;
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial
    begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        test_done;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge clock);
        #1 resetn = 1;
        acc(0, CT, 0);
        acc(1, 32'h1f00_0008, 32'hdead_beef);
        acc(0, 32'hff00_0008, 32'hdead_beef);
        acc(0, 32'hff00_0014, 0);
        acc(1, CT, 32'h0000_1400);
        acc(1, HI, 32'hffff_fca5);
        for (int i = 0; i < 4; i++)
        begin
            s = i;
            d = 32'h1fff_fd6f | {24'h0, s[1], 2'b00, s[0], 4'h0};
            acc(1, LO, d);
            load_entry_instr = 1; ut_access = 1;
            step;
            load_entry_instr = 0; ut_access = 0;
            chk("ut_wr", 1, ut_wr);
            chk("ut_index", 5, ut_index);
            chk("ut_vpn", 22'(22'h3f_ffff << sh[i]), ut_vpn);
            chk("ut_ppn", 19'(19'h7_ffff << sh[i]), ut_ppn);
            chk("ut_tag", 8'ha5, ut_tag);
            chk("ut_flags", d[8:0], ut_flags);
        end
        step;
        chk("valid", 1, valid_q[5]);
        acc(0, CT, 32'h0000_1400);
        acc(1, CT, 32'hffff_ffff);
        chk("flush", 1, flush_all_entries);
        acc(0, CT, mtr_pkg::MTR_CTL_WR_MASK);
        chk("valid", 0, {31'h0, |valid_q});
        chk("single", 1, single_space_select);
        acc(1, CT, 32'h0000_0004);
        flt(0, 32'h1234_5678, 0);
        flt(1, 32'h1234_5678, 1);
        acc(0, FA, 32'h1234_5678);
        acc(0, HI, 32'h1234_54a5);
        acc(1, CT, 32'h0000_0001);
        repeat (4) step;
        chk("mapping", 1, mapping_enable);
        flt(0, 32'h0000_0c00, 1);
        acc(1, FA, 32'h5555_aaaa);
        acc(0, FA, 32'h5555_aaaa);
        acc(1, CT, 32'h0008_0000);
        uta(2);
        acc(0, CT, 32'h0008_0800);
        uta(1);
        acc(0, CT, 32'h0008_0000);
        acc(1, CT, 32'h0008_f800);
        uta(1);
        acc(0, CT, 32'h0008_fc00);
        uta(1);
        acc(0, CT, 32'h0008_0000);
        acc(1, CT, 0);
        step;
        chk("victim", 3, it_victim);
        for (int j = 0; j < 4; j++)
        begin
            it_use_valid = 1; it_use_index = idx[j][1:0];
            step;
            it_use_valid = 0;
            step;
            chk("victim", vic[j], it_victim);
            chk("victim_ok", 1, it_victim_ok);
            acc(0, CT, {age[j], 26'h0});
        end
        chk("tag_cmp", 1, tag_compare_en);
        entry_shared = 1;
        acc(1, CT, 32'h0000_0200);
        chk("tag_cmp", 0, tag_compare_en);
        sq_access = 1; user_mode = 1;
        step;
        sq_access = 0;
        chk("sq_error", 1, sq_addr_error);
        chk("sq_block", 1, queue_user_block);
        acc(1, LO, 32'h0000_0100);
        manual_reset = 1;
        step;
        manual_reset = 0;
        acc(0, CT, 0);
        acc(0, LO, 32'h0000_0100);
        test_done;
    end
endmodule // mmu_translation_registers_tb
